// ==== include/sirq_defs.svh ====
`ifndef SIRQ_DEFS_SVH
`define SIRQ_DEFS_SVH
// What this block does
// - enable register at 0x06, resets to zero
// - bit0 reports tilt, needs tilt/flip enable
// - bit1 reports flip, needs tilt/flip enable
// - bit2 reports any-motion with any-motion enable
// - bit3 shake needs shake and any-motion enables
// - bit4 tilt-35 needs tilt-35 and any-motion enables
// - auto-clear off: reading 0x14 clears pending
// - auto-clear on: pending drops when condition ends
// - bit7 raises per-sample interrupt and flag, in wake state only
// - mode register 0x07 writable in any state
// - state field: 00 standby, 01 wake
// - mode bit4 enables clock-stuck-low watchdog
// - mode bit5 enables clock-stuck-high watchdog
// - mode bit6 selects push-pull, else open-drain
// - mode bit7 selects active-high, else low
// - rate register 0x08 selects output data rate
// - watchdog event idles slave, sets readable flag

// ==================================================
// register map
`define SIRQ_ADDR_DEV_STAT 8'h05
`define SIRQ_ADDR_INT_EN 8'h06
`define SIRQ_ADDR_MODE 8'h07
`define SIRQ_ADDR_RATE 8'h08
`define SIRQ_ADDR_INT_STAT 8'h14
`define SIRQ_RESET_VAL 8'h00
// ==================================================
// interrupt enable fields
`define SIRQ_IE_TILT 0
`define SIRQ_IE_FLIP 1
`define SIRQ_IE_ANYM 2
`define SIRQ_IE_SHAKE 3
`define SIRQ_IE_TILT35 4
`define SIRQ_IE_AUTOCLR 6
`define SIRQ_IE_ACQ 7
`define SIRQ_IE_MASK 8'hdf
// ==================================================
// motion control fields
`define SIRQ_MC_TF 0
`define SIRQ_MC_ANYM 2
`define SIRQ_MC_SHAKE 3
`define SIRQ_MC_TILT35 4
// ==================================================
// mode fields
`define SIRQ_MD_STATE_HI 1
`define SIRQ_MD_STATE_LO 0
`define SIRQ_MD_WDT_LOW 4
`define SIRQ_MD_WDT_HIGH 5
`define SIRQ_MD_PUSHPULL 6
`define SIRQ_MD_POL_HIGH 7
`define SIRQ_MD_MASK 8'hf3
`define SIRQ_STATE_WAKE 2'h1
// ==================================================
// rate and status fields
`define SIRQ_RATE_MASK 8'h07
`define SIRQ_ST_ACQ 7
`define SIRQ_DS_WDT 4
`define SIRQ_NUM_SRC 5
// ==================================================
// timing
`define SIRQ_CLK_PERIOD_NS 25
`define SIRQ_WDT_TIME_NS 50000
`define SIRQ_WDT_CYC \
  ((`SIRQ_WDT_TIME_NS + `SIRQ_CLK_PERIOD_NS - 1) / `SIRQ_CLK_PERIOD_NS)
`endif

// ==== include/sirq_pkg.sv ====
package sirq_pkg;
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_COUNT = 3'b010,
    WD_HOLD = 3'b100
  } sirq_wd_state_e;
  typedef enum logic [2:0] {
    RATE_128 = 3'h0,
    RATE_256 = 3'h1,
    RATE_512 = 3'h2,
    RATE_1024 = 3'h5
  } sirq_rate_e;
endpackage : sirq_pkg

// ==== include/sirq_wdt_if.sv ====
`timescale 1ns/100ps
interface sirq_wdt_if;
  logic enable;
  logic lineLevel;
  logic fire;
  modport ctrl (output enable, output lineLevel, input fire);
  modport dog (input enable, input lineLevel, output fire);
endinterface : sirq_wdt_if

// ==== logic/sirq_stall_wdog.sv ====
`timescale 1ns/100ps
`include "sirq_defs.svh"
module sirq_stall_wdog import sirq_pkg::*; #(
  parameter int TIMEOUT = `SIRQ_WDT_CYC,
  parameter logic STALL_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control side
  sirq_wdt_if.dog wd
);
  localparam int CW = $clog2(TIMEOUT + 1);

  if (TIMEOUT < 2) begin : g_bad_timeout
    $error("watchdog timeout too short");
  end

  sirq_wd_state_e state_r, state_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic fire_r, fire_nxt;
  logic stalled;

  assign stalled = wd.enable && (wd.lineLevel == STALL_LEVEL);
  assign wd.fire = fire_r;

  // ==================================================
  // stall counter
  // after firing it waits for the line to move, so one stall fires once
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    fire_nxt = 1'b0;
    case (state_r)
      WD_IDLE: begin
        count_nxt = '0;
        if (stalled) state_nxt = WD_COUNT;
      end
      WD_COUNT: begin
        if (!stalled) begin
          state_nxt = WD_IDLE;
        end else if (count_r == CW'(TIMEOUT - 2)) begin
          fire_nxt = 1'b1;
          state_nxt = WD_HOLD;
        end else begin
          count_nxt = count_r + 1'b1;
        end
      end
      WD_HOLD: begin
        if (!stalled) state_nxt = WD_IDLE;
      end
      default: state_nxt = WD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= WD_IDLE;
      count_r <= '0;
      fire_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      fire_r <= fire_nxt;
    end
  end

  a_fire_once: assert property (@(posedge core_clk) disable iff (rst)
    fire_r |=> !fire_r)
    else $error("watchdog fired twice in a row");
endmodule : sirq_stall_wdog

// ==== logic/sirq_irq_mode_regs.sv ====
`timescale 1ns/100ps
`include "sirq_defs.svh"
module sirq_irq_mode_regs import sirq_pkg::*; #(
  parameter int WDT_CYC = `SIRQ_WDT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port from the serial slave
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // serial clock line, asynchronous
  input wire logic sclIn,
  // slave control
  output logic slaveIdleReq,
  // motion block
  input wire logic [7:0] motionCtrl,
  input wire logic [4:0] srcCond,
  input wire logic sampleDone,
  // operating state and rate
  output logic wakeRun,
  output logic [2:0] rateSel,
  // interrupt pin
  output logic interruptOutputPinOut,
  output logic interruptOutputPinOe
);
  localparam int NS = `SIRQ_NUM_SRC;

  if (WDT_CYC < 2) begin : g_bad_cyc
    $error("watchdog count too short");
  end

  // ==================================================
  // configuration registers
  logic [7:0] intEn_r, intEn_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] rate_r, rate_nxt;

  always_comb begin
    intEn_nxt = intEn_r;
    mode_nxt = mode_r;
    rate_nxt = rate_r;
    if (regWrEn) begin
      case (regAddr)
        `SIRQ_ADDR_INT_EN: intEn_nxt = regWrData & `SIRQ_IE_MASK;
        // accepted whatever the current state; bits 2 and 3 forced to zero
        `SIRQ_ADDR_MODE: mode_nxt = regWrData & `SIRQ_MD_MASK;
        `SIRQ_ADDR_RATE: rate_nxt = regWrData & `SIRQ_RATE_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      intEn_r <= `SIRQ_RESET_VAL;
      mode_r <= `SIRQ_RESET_VAL;
      rate_r <= `SIRQ_RESET_VAL;
    end else begin
      intEn_r <= intEn_nxt;
      mode_r <= mode_nxt;
      rate_r <= rate_nxt;
    end
  end

  logic autoClr;
  logic polHigh;
  logic pushPull;
  logic isWake;
  assign autoClr = intEn_r[`SIRQ_IE_AUTOCLR];
  assign polHigh = mode_r[`SIRQ_MD_POL_HIGH];
  assign pushPull = mode_r[`SIRQ_MD_PUSHPULL];
  // reserved state codes are held but never run the sampler
  assign isWake = (mode_r[`SIRQ_MD_STATE_HI:`SIRQ_MD_STATE_LO]
    == `SIRQ_STATE_WAKE);

  // ==================================================
  // serial clock synchroniser and stall watchdogs
  logic sclMeta_r, sclSync_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
    end else begin
      sclMeta_r <= sclIn;
      sclSync_r <= sclMeta_r;
    end
  end

  sirq_wdt_if wdLow ();
  sirq_wdt_if wdHigh ();
  assign wdLow.enable = mode_r[`SIRQ_MD_WDT_LOW];
  assign wdLow.lineLevel = sclSync_r;
  assign wdHigh.enable = mode_r[`SIRQ_MD_WDT_HIGH];
  assign wdHigh.lineLevel = sclSync_r;

  sirq_stall_wdog #(.TIMEOUT(WDT_CYC), .STALL_LEVEL(1'b0)) uWdLow (
    .core_clk(core_clk),
    .rst(rst),
    .wd(wdLow.dog)
  );

  sirq_stall_wdog #(.TIMEOUT(WDT_CYC), .STALL_LEVEL(1'b1)) uWdHigh (
    .core_clk(core_clk),
    .rst(rst),
    .wd(wdHigh.dog)
  );

  logic wdFire;
  assign wdFire = wdLow.fire || wdHigh.fire;

  // ==================================================
  // source qualification
  logic [NS-1:0] qualCond;
  logic anymOn;

  always_comb begin
    anymOn = motionCtrl[`SIRQ_MC_ANYM];
    qualCond = '0;
    qualCond[`SIRQ_IE_TILT] = srcCond[`SIRQ_IE_TILT]
      && motionCtrl[`SIRQ_MC_TF];
    qualCond[`SIRQ_IE_FLIP] = srcCond[`SIRQ_IE_FLIP]
      && motionCtrl[`SIRQ_MC_TF];
    qualCond[`SIRQ_IE_ANYM] = srcCond[`SIRQ_IE_ANYM] && anymOn;
    qualCond[`SIRQ_IE_SHAKE] = srcCond[`SIRQ_IE_SHAKE] && anymOn
      && motionCtrl[`SIRQ_MC_SHAKE];
    qualCond[`SIRQ_IE_TILT35] = srcCond[`SIRQ_IE_TILT35] && anymOn
      && motionCtrl[`SIRQ_MC_TILT35];
    qualCond = qualCond & intEn_r[NS-1:0];
  end

  // ==================================================
  // pending flags; a new event beats a clear in the same cycle
  logic [NS-1:0] pendSrc_r, pendSrc_nxt;
  logic pendAcq_r, pendAcq_nxt;
  logic wdtFlag_r, wdtFlag_nxt;
  logic statRead;
  logic acqEvent;

  assign statRead = regRdEn && (regAddr == `SIRQ_ADDR_INT_STAT);
  // samples only happen while awake
  assign acqEvent = sampleDone && isWake && intEn_r[`SIRQ_IE_ACQ];

  always_comb begin
    pendSrc_nxt = pendSrc_r;
    pendAcq_nxt = pendAcq_r;
    if (autoClr) begin
      pendSrc_nxt = pendSrc_r & qualCond;
    end else if (statRead) begin
      pendSrc_nxt = '0;
    end
    // per-sample flag has no lasting condition, so only a read clears it
    if (statRead) pendAcq_nxt = 1'b0;
    pendSrc_nxt = pendSrc_nxt | qualCond;
    if (acqEvent) pendAcq_nxt = 1'b1;
  end

  always_comb begin
    wdtFlag_nxt = wdtFlag_r;
    if (statRead) wdtFlag_nxt = 1'b0;
    if (wdFire) wdtFlag_nxt = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pendSrc_r <= '0;
      pendAcq_r <= 1'b0;
      wdtFlag_r <= 1'b0;
    end else begin
      pendSrc_r <= pendSrc_nxt;
      pendAcq_r <= pendAcq_nxt;
      wdtFlag_r <= wdtFlag_nxt;
    end
  end

  // ==================================================
  // register outputs
  logic [7:0] rdData_r, rdData_nxt;
  logic idle_r, idle_nxt;
  logic wake_r;
  logic [2:0] rateOut_r;

  always_comb begin
    rdData_nxt = rdData_r;
    if (regRdEn) begin
      case (regAddr)
        `SIRQ_ADDR_DEV_STAT: begin
          rdData_nxt = '0;
          rdData_nxt[`SIRQ_MD_STATE_HI:`SIRQ_MD_STATE_LO] =
            mode_r[`SIRQ_MD_STATE_HI:`SIRQ_MD_STATE_LO];
          rdData_nxt[`SIRQ_DS_WDT] = wdtFlag_r;
        end
        `SIRQ_ADDR_INT_EN: rdData_nxt = intEn_r;
        `SIRQ_ADDR_MODE: rdData_nxt = mode_r;
        `SIRQ_ADDR_RATE: rdData_nxt = rate_r;
        `SIRQ_ADDR_INT_STAT: begin
          rdData_nxt = '0;
          rdData_nxt[NS-1:0] = pendSrc_r;
          rdData_nxt[`SIRQ_ST_ACQ] = pendAcq_r;
        end
        default: rdData_nxt = '0;
      endcase
    end
  end

  assign idle_nxt = wdFire;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_r <= '0;
      idle_r <= 1'b0;
      wake_r <= 1'b0;
      rateOut_r <= '0;
    end else begin
      rdData_r <= rdData_nxt;
      idle_r <= idle_nxt;
      wake_r <= isWake;
      rateOut_r <= rate_r[2:0];
    end
  end

  assign regRdData = rdData_r;
  assign slaveIdleReq = idle_r;
  assign wakeRun = wake_r;
  assign rateSel = rateOut_r;

  // ==================================================
  // interrupt pin
  logic pinOut_r, pinOut_nxt;
  logic pinOe_r, pinOe_nxt;
  logic irqActive;
  logic pinLevel;

  assign irqActive = (|pendSrc_r) || pendAcq_r;
  assign pinLevel = irqActive ? polHigh : !polHigh;

  // open-drain can only pull low; a high level is left to the pull-up
  always_comb begin
    if (pushPull) begin
      pinOut_nxt = pinLevel;
      pinOe_nxt = 1'b1;
    end else begin
      pinOut_nxt = 1'b0;
      pinOe_nxt = !pinLevel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
    end
  end

  assign interruptOutputPinOut = pinOut_r;
  assign interruptOutputPinOe = pinOe_r;

  // ==================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_stat_read;
    regRdEn && regAddr == `SIRQ_ADDR_INT_STAT;
  endsequence

  sequence s_no_new_event;
    qualCond == '0 && !acqEvent && !wdFire;
  endsequence

  // watched while reset is applied, so the default disable is overridden
  a_reset_values: assert property (disable iff (1'b0)
    rst |=> intEn_r == '0
    && mode_r == '0 && rate_r == '0)
    else $error("registers not zero after reset");

  a_tilt_gated: assert property ($rose(pendSrc_r[0]) |->
    $past(intEn_r[0] && motionCtrl[`SIRQ_MC_TF] && srcCond[0]))
    else $error("tilt pending without its enables");

  a_flip_gated: assert property ($rose(pendSrc_r[1]) |->
    $past(intEn_r[1] && motionCtrl[`SIRQ_MC_TF]))
    else $error("flip pending without its enables");

  a_anym_gated: assert property ($rose(pendSrc_r[2]) |->
    $past(intEn_r[2] && motionCtrl[`SIRQ_MC_ANYM]))
    else $error("any-motion pending without its enables");

  a_shake_gated: assert property ($rose(pendSrc_r[3]) |->
    $past(intEn_r[3] && motionCtrl[`SIRQ_MC_SHAKE] && anymOn))
    else $error("shake pending without both enables");

  a_tilt35_gated: assert property ($rose(pendSrc_r[4]) |->
    $past(intEn_r[4] && motionCtrl[`SIRQ_MC_TILT35] && anymOn))
    else $error("tilt-35 pending without both enables");

  a_read_clears: assert property (s_stat_read and s_no_new_event
    |=> pendSrc_r == '0 && !pendAcq_r && !wdtFlag_r)
    else $error("status read did not clear pending");

  a_latch_holds: assert property (!autoClr && !statRead
    && pendSrc_r[2] |=> pendSrc_r[2])
    else $error("latched source dropped without a read");

  a_auto_drop: assert property (autoClr && !qualCond[2]
    |=> !pendSrc_r[2])
    else $error("self-clearing source stayed pending");

  a_acq_sets: assert property (acqEvent |=> pendAcq_r)
    else $error("sample event did not set flag");

  a_acq_off: assert property (!intEn_r[`SIRQ_IE_ACQ] && !pendAcq_r
    |=> !pendAcq_r)
    else $error("per-sample flag set while disabled");

  a_mode_write: assert property (regWrEn
    && regAddr == `SIRQ_ADDR_MODE |=> mode_r == ($past(regWrData)
    & `SIRQ_MD_MASK))
    else $error("mode write not taken");

  a_wake_out: assert property (isWake |=> wakeRun)
    else $error("wake not reported");

  a_wdt_event: assert property (wdFire |=> slaveIdleReq
    && wdtFlag_r)
    else $error("watchdog event not acted on");

  // fire is registered, so it answers the enable one cycle late
  a_low_stall: assert property (!wdLow.enable |=> !wdLow.fire)
    else $error("low watchdog fired while disabled");

  a_high_stall: assert property (!wdHigh.enable ##1 !wdHigh.enable
    |-> !wdHigh.fire)
    else $error("high watchdog fired while disabled");

  a_pin_level: assert property (pushPull && irqActive
    |=> interruptOutputPinOe && interruptOutputPinOut == $past(polHigh))
    else $error("push-pull pin not asserted");

  a_open_drain: assert property (!pushPull && !polHigh
    && irqActive |=> interruptOutputPinOe && !interruptOutputPinOut)
    else $error("open-drain pin not pulling low");

  a_pin_release: assert property (!pushPull && polHigh
    && irqActive |=> !interruptOutputPinOe)
    else $error("open-drain active-high pin still driven");
endmodule : sirq_irq_mode_regs

// ==== tb/sirq_host_model.sv ====
`timescale 1ns/100ps
module sirq_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [7:0] regRdData,
  // serial clock line, pulled up while idle
  output logic sclIn
);
  // ==================================================
  // idle levels
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    sclIn = 1'b1;
  end

  // ==================================================
  // register access
  // released lines show the inverse so stale data cannot pass for valid
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask : rd

  // ==================================================
  // serial clock frame
  // 200 ns period, phase unrelated to the core clock; stands at last after
  task frame(input int n, input logic last);
    #7;
    repeat (n) begin
      sclIn = 1'b0;
      #100;
      sclIn = 1'b1;
      #100;
    end
    sclIn = last;
  endtask : frame
endmodule : sirq_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module testbench import sirq_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] motionCtrl = 8'h00;
  logic [4:0] srcCond = 5'h00;
  logic sampleDone = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, sclIn, slaveIdleReq, wakeRun, pinOut, pinOe;
  logic [2:0] rateSel;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] need [5] = '{8'h01, 8'h01, 8'h04, 8'h0c, 8'h14};
  logic [7:0] miss [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h10};

  always #12.5 core_clk = ~core_clk;

  sirq_host_model u_host (.core_clk(core_clk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .sclIn(sclIn));

  // short watchdog so a stall fits in a few dozen cycles
  sirq_irq_mode_regs #(.WDT_CYC(8)) u_dut (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .sclIn(sclIn),
    .slaveIdleReq(slaveIdleReq), .motionCtrl(motionCtrl),
    .srcCond(srcCond), .sampleDone(sampleDone), .wakeRun(wakeRun),
    .rateSel(rateSel), .interruptOutputPinOut(pinOut),
    .interruptOutputPinOe(pinOe));

  // ==================================================
  // helpers
  task end_of_test;
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    `CHK(d, e)
  endtask : rdchk

  // open drain only drives when the wanted level is low
  task pin(input logic lvl, input logic pp);
    `CHK(pinOe, pp | ~lvl)
    if (pp | ~lvl) `CHK(pinOut, lvl)
  endtask : pin

  task src(input int i, input logic [7:0] mc, input logic ok);
    u_host.wr(8'h06, 8'h01 << i);
    @(posedge core_clk);
    motionCtrl <= mc;
    srcCond <= 5'h01 << i;
    cyc(3);
    pin(~ok, 1'b0);
    @(posedge core_clk);
    srcCond <= 5'h00;
    cyc(3);
    rdchk(8'h14, ok ? 8'h01 << i : 8'h00);
    rdchk(8'h14, 8'h00);
    cyc(3);
    pin(1'b1, 1'b0);
  endtask : src

  task sample;
    @(posedge core_clk);
    sampleDone <= 1'b1;
    @(posedge core_clk);
    sampleDone <= 1'b0;
    cyc(3);
  endtask : sample

  task dog(input int exp);
    int cnt;
    cnt = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (slaveIdleReq === 1'b1) cnt++;
    end
    `CHK(cnt, exp)
  endtask : dog

  // ==================================================
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    `CHK(pinOe, 1'b0)
    rdchk(8'h06, 8'h00);
    rdchk(8'h07, 8'h00);
    rdchk(8'h08, 8'h00);
    u_host.wr(8'h06, 8'hff);
    rdchk(8'h06, 8'hdf);
    u_host.wr(8'h08, 8'hff);
    rdchk(8'h08, 8'h07);
    u_host.wr(8'h06, 8'h00);
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h07, 8'(c) | 8'h0c);
      cyc(2);
      `CHK(wakeRun, c == 1)
      rdchk(8'h07, 8'(c));
      rdchk(8'h05, 8'(c));
    end
    for (int k = 0; k < 8; k++) begin
      u_host.wr(8'h08, 8'(k));
      cyc(2);
      `CHK(rateSel, 3'(k))
    end
    u_host.wr(8'h07, 8'h00);
    for (int i = 0; i < 5; i++) begin
      src(i, need[i], 1'b1);
      src(i, miss[i], 1'b0);
    end
    // self clearing: pin follows the condition without any read
    u_host.wr(8'h06, 8'h44);
    motionCtrl <= 8'h04;
    srcCond <= 5'h04;
    cyc(3);
    pin(1'b0, 1'b0);
    @(posedge core_clk);
    srcCond <= 5'h00;
    cyc(3);
    pin(1'b1, 1'b0);
    rdchk(8'h14, 8'h00);
    for (int m = 0; m < 4; m++) begin
      u_host.wr(8'h07, {m[1], m[0], 6'h00});
      srcCond <= 5'h04;
      cyc(3);
      pin(m[1], m[0]);
      @(posedge core_clk);
      srcCond <= 5'h00;
      cyc(3);
      pin(~m[1], m[0]);
    end
    u_host.wr(8'h06, 8'h80);
    u_host.wr(8'h07, 8'h01);
    sample();
    pin(1'b0, 1'b0);
    rdchk(8'h14, 8'h80);
    rdchk(8'h14, 8'h00);
    u_host.wr(8'h06, 8'h00);
    sample();
    rdchk(8'h14, 8'h00);
    u_host.wr(8'h06, 8'h80);
    u_host.wr(8'h07, 8'h00);
    sample();
    rdchk(8'h14, 8'h00);
    u_host.wr(8'h06, 8'h00);
    // stall low, then high, then low with both watchdogs off
    u_host.wr(8'h07, 8'h10);
    u_host.frame(4, 1'b0);
    dog(1);
    rdchk(8'h05, 8'h10);
    rdchk(8'h14, 8'h00);
    rdchk(8'h05, 8'h00);
    u_host.wr(8'h07, 8'h20);
    u_host.frame(4, 1'b1);
    dog(1);
    u_host.wr(8'h07, 8'h00);
    u_host.frame(4, 1'b0);
    dog(0);
    end_of_test();
  end
endmodule : testbench
